// File: design/aics_conv_timer.sv
// Conversion timer: detects the start falling edge and times one conversion.
// Assumes the start line is synchronous to the clock.
`timescale 1ns/1ps
module aics_conv_timer
   import aics_pkg::*;
#(
   parameter int unsigned CONV_LEN  = CONV_CYCLES,
   parameter int unsigned ABORT_LEN = ABORT_EDGE
)(
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   input  wire logic start_n_in,
   output logic      busy_out,
   output logic      start_out,
   output logic      done_out,
   output logic      abort_out
);

   typedef struct packed {
      logic             prev;
      logic             busy;
      logic [CNT_W-1:0] cnt;
      logic             start;
      logic             done;
      logic             abort;
   } aics_tmr_t;

   localparam aics_tmr_t TMR_RST = '{prev: 1'b1, busy: 1'b0, cnt: '0,
                                     start: 1'b0, done: 1'b0, abort: 1'b0};
   localparam logic [CNT_W-1:0] ABORT_CNT = ABORT_LEN[CNT_W-1:0];
   localparam logic [CNT_W-1:0] LAST_CNT  = CNT_W'(CONV_LEN - 1);

   aics_tmr_t q;
   aics_tmr_t d;

   always_comb
   begin
      d = q;
      // Pulses hold while frozen, so the sequencer still sees them later
      if (ce_in)
      begin
         d.start = 1'b0;
         d.done  = 1'b0;
         d.abort = 1'b0;
         d.prev  = start_n_in;
         if (!q.busy)
         begin
            // Edges while busy are ignored, only idle falling edges start
            if (q.prev && !start_n_in)
            begin
               d.busy  = 1'b1;
               d.cnt   = '0;
               d.start = 1'b1;
            end
         end
         else
         begin
            d.cnt = q.cnt + 1'b1;
            // Releasing start too early throws the conversion away
            if (start_n_in && q.cnt < ABORT_CNT)
            begin
               d.busy  = 1'b0;
               d.abort = 1'b1;
            end
            else if (q.cnt == LAST_CNT)
            begin
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         q <= TMR_RST;
      else
         q <= d;
   end

   assign busy_out  = q.busy;
   assign start_out = q.start;
   assign done_out  = q.done;
   assign abort_out = q.abort;

   property p_start_edge;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && q.prev && !start_n_in && !q.busy) |=> (busy_out && start_out);
   endproperty
   a_start_edge: assert property (p_start_edge)
      else $error("falling start edge did not begin a conversion");

   property p_early_release;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && q.busy && start_n_in && q.cnt < ABORT_CNT) |=> (abort_out && !done_out);
   endproperty
   a_early_release: assert property (p_early_release)
      else $error("early start release did not abort");

endmodule

// File: design/aics_pkg.sv
// Package for the input channel sequencer: register map, control field layout,
// sequencing modes, conversion timing and shared channel functions.
// Assumes eight analog inputs and an 8-bit register port.
package aics_pkg;

   localparam int unsigned NUM_CH      = 8;
   localparam int unsigned CH_W        = 3;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 2;
   localparam int unsigned CNT_W       = 5;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL   = 2'h0;
   localparam logic [ADDR_W-1:0] REG_MASK   = 2'h1;
   localparam logic [ADDR_W-1:0] REG_STATUS = 2'h2;

   // Control word field positions
   localparam int unsigned CTRL_CFG_LO  = 0;
   localparam int unsigned CTRL_CFG_HI  = 1;
   localparam int unsigned CTRL_AUTO    = 2;
   localparam int unsigned CTRL_MSEL    = 3;
   localparam int unsigned CTRL_CH_LSB  = 4;
   localparam int unsigned CTRL_REF     = 7;

   // Status word field positions
   localparam int unsigned STAT_BUSY    = 0;
   localparam int unsigned STAT_PTR_LSB = 1;
   localparam int unsigned STAT_MODE_LSB = 4;
   localparam int unsigned STAT_ABORT   = 6;

   // Input configuration codes {hi, lo}
   localparam logic [1:0] CFG_SINGLE   = 2'h0;
   localparam logic [1:0] CFG_PSEUDO4  = 2'h1;
   localparam logic [1:0] CFG_DIFF4    = 2'h2;
   localparam logic [1:0] CFG_PSEUDO7  = 2'h3;

   localparam logic [CH_W-1:0]   CH_ZERO    = 3'h0;
   localparam logic [CH_W-1:0]   CH_ONE     = 3'h1;
   localparam logic [CH_W-1:0]   CH_COMMON  = 3'h7;
   localparam logic [CH_W-1:0]   CH_TOP     = 3'h7;
   localparam logic [NUM_CH-1:0] MASK_RESET = 8'h00;

   // Converter clock edges: abort window and whole conversion length
   localparam int unsigned ABORT_EDGE  = 14;
   localparam int unsigned CONV_CYCLES = 16;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_MASK   = 2'b01,
      MODE_CONSEC = 2'b10
   } aics_mode_t;

   // Next enabled mask channel above cur, wrapping; cur if the mask is empty
   function automatic logic [CH_W-1:0] aics_next_ch(input logic [NUM_CH-1:0] mask,
                                                   input logic [CH_W-1:0]   cur);
      logic [CH_W-1:0] cand;
      logic            found;
      aics_next_ch = cur;
      found        = 1'b0;
      for (int i = 1; i <= NUM_CH; i++)
      begin
         cand = cur + i[CH_W-1:0];
         if (!found && mask[cand])
         begin
            aics_next_ch = cand;
            found        = 1'b1;
         end
      end
   endfunction

   // Mux routing {neg_gnd, neg, pos} for a configuration and channel code
   function automatic logic [2*CH_W:0] aics_route(input logic [1:0]      cfg,
                                                 input logic [CH_W-1:0] ch);
      case (cfg)
         CFG_PSEUDO4: aics_route = {1'b0, ch[2:1], 1'b1, ch[2:1], 1'b0};
         CFG_DIFF4:   aics_route = {1'b0, ch[2:1], ~ch[0], ch[2:1], ch[0]};
         CFG_PSEUDO7: aics_route = {1'b0, CH_COMMON, ch};
         default:     aics_route = {1'b1, CH_ZERO, ch};
      endcase
   endfunction

endpackage

// File: design/aics_sequencer.sv
// Input channel sequencer top: control word, channel mask, sequencing and mux routing.
// Assumes a synchronous register port and that the converter runs on SYS_CLK_IN.
`timescale 1ns/1ps
// Notes on behaviour
// - Config lo=1,hi=0 gives four pseudo pairs; both 1 gives seven pseudo inputs.
// - Seven-input mode measures every input against the eighth common input.
// - Sequencing bits 00 convert the channel named by the select field.
// - In single scheme each control write loads the next conversion channel.
// - Bits auto 0, mask-select 1 take channels from the mask register.
// - Mask scheme starts at lowest enabled channel, then next higher enabled.
// - After highest enabled channel the pointer wraps to lowest enabled.
// - A running sequence advances per conversion with no further writes.
// - Sequence program holds until a write carries other than auto 1, select 0.
// - Both bits 1 convert ascending from channel 0 to the select field.
// - Consecutive scheme starts at channel 0 with no mask write needed.
// - Consecutive scheme restarts at channel 0 after the final channel.
// - Source bit 1 picks on-chip voltage source, 0 the external source.
// - Config 00 gives eight independent single-ended channels.
// - Config lo=0,hi=1 gives four fully differential pairs.
// - Host falling edge on start converts current channel and moves sequence.
module aics_sequencer
   import aics_pkg::*;
#(
   parameter int unsigned CONV_LEN  = CONV_CYCLES,
   parameter int unsigned ABORT_LEN = ABORT_EDGE
)(
   input  wire logic              SYS_CLK_IN,
   input  wire logic              RST_IN,
   input  wire logic              CE_IN,
   input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input  wire logic [DATA_W-1:0] REG_WDATA_IN,
   input  wire logic              REG_WR_IN,
   input  wire logic              REG_RD_IN,
   input  wire logic              CONV_START_N_IN,
   output logic [DATA_W-1:0]      REG_RDATA_OUT,
   output logic                   BUSY_OUT,
   output logic                   CONV_DONE_OUT,
   output logic                   CONV_ABORT_OUT,
   output logic [CH_W-1:0]        CONV_CH_OUT,
   output logic [CH_W-1:0]        POS_SEL_OUT,
   output logic [CH_W-1:0]        NEG_SEL_OUT,
   output logic                   NEG_GND_OUT,
   output logic                   REF_INTERNAL_OUT
);

   typedef struct packed {
      logic [1:0]        cfg;
      logic              ref_int;
      logic [CH_W-1:0]   ch_field;
      aics_mode_t        mode;
      logic [CH_W-1:0]   ptr;
      logic [CH_W-1:0]   last;
      logic [NUM_CH-1:0] mask;
      logic [CH_W-1:0]   conv_ch;
      logic              aborted;
      logic [DATA_W-1:0] rdata;
      logic [CH_W-1:0]   pos;
      logic [CH_W-1:0]   neg;
      logic              neg_gnd;
   } aics_state_t;

   localparam aics_state_t ST_RST = '{cfg: CFG_SINGLE, ref_int: 1'b0, ch_field: CH_ZERO,
                                      mode: MODE_SINGLE, ptr: CH_ZERO, last: CH_ZERO,
                                      mask: MASK_RESET, conv_ch: CH_ZERO, aborted: 1'b0,
                                      rdata: '0, pos: CH_ZERO, neg: CH_ZERO,
                                      neg_gnd: 1'b1};

   aics_state_t q;
   aics_state_t d;

   logic t_busy;
   logic t_start;
   logic t_done;
   logic t_abort;

   aics_conv_timer #(
      .CONV_LEN  (CONV_LEN),
      .ABORT_LEN (ABORT_LEN)
   ) u_timer (
      .clk_in     (SYS_CLK_IN),
      .rst_in     (RST_IN),
      .ce_in      (CE_IN),
      .start_n_in (CONV_START_N_IN),
      .busy_out   (t_busy),
      .start_out  (t_start),
      .done_out   (t_done),
      .abort_out  (t_abort)
   );

   logic              wr_ctrl;
   logic              wr_mask;
   logic [CH_W-1:0]   w_ch;
   logic [1:0]        w_seq;
   logic [CH_W-1:0]   route_ch;
   logic [2*CH_W:0]   route;

   assign wr_ctrl = CE_IN && REG_WR_IN && (REG_ADDR_IN == REG_CTRL);
   assign wr_mask = CE_IN && REG_WR_IN && (REG_ADDR_IN == REG_MASK);
   assign w_ch    = REG_WDATA_IN[CTRL_CH_LSB +: CH_W];
   assign w_seq   = {REG_WDATA_IN[CTRL_AUTO], REG_WDATA_IN[CTRL_MSEL]};

   always_comb
   begin
      d        = q;
      route_ch = CH_ZERO;
      route    = '0;
      if (CE_IN)
      begin
         // Of the conversion events, only a completed one moves the pointer
         if (t_done)
         begin
            case (q.mode)
               MODE_MASK:   d.ptr = aics_next_ch(q.mask, q.ptr);
               MODE_CONSEC: d.ptr = (q.ptr == q.last) ? CH_ZERO : q.ptr + CH_ONE;
               default:     d.ptr = q.ptr;
            endcase
         end
         if (t_start)
         begin
            d.conv_ch = q.ptr;
            d.aborted = 1'b0;
         end
         if (t_abort)
            d.aborted = 1'b1;
         if (wr_ctrl)
         begin
            d.cfg     = {REG_WDATA_IN[CTRL_CFG_HI], REG_WDATA_IN[CTRL_CFG_LO]};
            d.ref_int = REG_WDATA_IN[CTRL_REF];
            // Setup writes win over a same-cycle advance
            case (w_seq)
               2'b00:
               begin
                  d.mode     = MODE_SINGLE;
                  d.ch_field = w_ch;
                  d.ptr      = w_ch;
               end
               2'b01:
               begin
                  d.mode     = MODE_MASK;
                  d.ch_field = w_ch;
                  d.ptr      = aics_next_ch(q.mask, CH_TOP);
               end
               2'b11:
               begin
                  d.mode     = MODE_CONSEC;
                  d.ch_field = w_ch;
                  d.last     = w_ch;
                  d.ptr      = CH_ZERO;
               end
               default: ; // Keep the running program untouched
            endcase
         end
         if (wr_mask)
         begin
            d.mask = REG_WDATA_IN;
            if (d.mode == MODE_MASK)
               d.ptr = aics_next_ch(REG_WDATA_IN, CH_TOP);
         end
         d.rdata = '0;
         if (REG_RD_IN)
         begin
            case (REG_ADDR_IN)
               REG_CTRL:
               begin
                  d.rdata[CTRL_CFG_LO]             = q.cfg[0];
                  d.rdata[CTRL_CFG_HI]             = q.cfg[1];
                  d.rdata[CTRL_AUTO]               = (q.mode == MODE_CONSEC);
                  d.rdata[CTRL_MSEL]               = (q.mode != MODE_SINGLE);
                  d.rdata[CTRL_CH_LSB +: CH_W]     = q.ch_field;
                  d.rdata[CTRL_REF]                = q.ref_int;
               end
               REG_MASK:   d.rdata = q.mask;
               REG_STATUS:
               begin
                  d.rdata[STAT_BUSY]               = t_busy;
                  d.rdata[STAT_PTR_LSB +: CH_W]    = q.ptr;
                  d.rdata[STAT_MODE_LSB +: 2]      = q.mode;
                  d.rdata[STAT_ABORT]              = q.aborted;
               end
               default:    d.rdata = '0;
            endcase
         end
         // Mux holds the sampled channel during a conversion
         route_ch  = (t_busy || t_start) ? d.conv_ch : d.ptr;
         route     = aics_route(d.cfg, route_ch);
         d.pos     = route[CH_W-1:0];
         d.neg     = route[2*CH_W-1:CH_W];
         d.neg_gnd = route[2*CH_W];
      end
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
         q <= ST_RST;
      else
         q <= d;
   end

   assign REG_RDATA_OUT    = q.rdata;
   assign BUSY_OUT         = t_busy;
   assign CONV_DONE_OUT    = t_done;
   assign CONV_ABORT_OUT   = t_abort;
   assign CONV_CH_OUT      = q.conv_ch;
   assign POS_SEL_OUT      = q.pos;
   assign NEG_SEL_OUT      = q.neg;
   assign NEG_GND_OUT      = q.neg_gnd;
   assign REF_INTERNAL_OUT = q.ref_int;

   sequence s_ctrl_wr(logic [1:0] seq);
      wr_ctrl && (w_seq == seq);
   endsequence

   property p_single_load;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      s_ctrl_wr(2'b00) |=> (q.ptr == $past(w_ch)) && (q.mode == MODE_SINGLE);
   endproperty
   a_single_load: assert property (p_single_load)
      else $error("single-channel write did not load the channel");

   property p_mask_setup;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (s_ctrl_wr(2'b01) and !wr_mask)
         |=> (q.mode == MODE_MASK) && (q.ptr == aics_next_ch(q.mask, CH_TOP));
   endproperty
   a_mask_setup: assert property (p_mask_setup)
      else $error("mask scheme did not start at lowest enabled channel");

   property p_mask_step;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_done && q.mode == MODE_MASK && !REG_WR_IN)
         |=> q.ptr == aics_next_ch($past(q.mask), $past(q.ptr));
   endproperty
   a_mask_step: assert property (p_mask_step)
      else $error("mask sequence did not step to next enabled channel");

   property p_consec_setup;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      s_ctrl_wr(2'b11) |=> (q.ptr == CH_ZERO) && (q.last == $past(w_ch));
   endproperty
   a_consec_setup: assert property (p_consec_setup)
      else $error("consecutive setup did not point at channel zero");

   property p_consec_wrap;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_done && q.mode == MODE_CONSEC && !REG_WR_IN)
         |=> q.ptr == (($past(q.ptr) == $past(q.last)) ? CH_ZERO : $past(q.ptr) + CH_ONE);
   endproperty
   a_consec_wrap: assert property (p_consec_wrap)
      else $error("consecutive sequence stepped or wrapped wrongly");

   property p_keep_program;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (s_ctrl_wr(2'b10) and !t_done and !wr_mask)
         |=> $stable(q.ptr) && $stable(q.mode) && $stable(q.last);
   endproperty
   a_keep_program: assert property (p_keep_program)
      else $error("keep write disturbed the sequence program");

   property p_abort_hold;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_abort && !REG_WR_IN) |=> $stable(q.ptr) && q.aborted;
   endproperty
   a_abort_hold: assert property (p_abort_hold)
      else $error("aborted conversion moved the pointer");

   property p_routing;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (q.cfg == CFG_PSEUDO7 |-> NEG_SEL_OUT == CH_COMMON && !NEG_GND_OUT) and
      (q.cfg == CFG_SINGLE  |-> NEG_GND_OUT) and
      (q.cfg == CFG_DIFF4   |-> NEG_SEL_OUT[1] == POS_SEL_OUT[1] &&
                                NEG_SEL_OUT[0] == !POS_SEL_OUT[0]) and
      (q.cfg == CFG_PSEUDO4 |-> NEG_SEL_OUT[0] && !POS_SEL_OUT[0]);
   endproperty
   a_routing: assert property (p_routing)
      else $error("mux routing does not match input configuration");

   property p_ref_select;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      wr_ctrl |=> REF_INTERNAL_OUT == $past(REG_WDATA_IN[CTRL_REF]);
   endproperty
   a_ref_select: assert property (p_ref_select)
      else $error("voltage source select not taken from control write");

   property p_sample_ch;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_start) |=> CONV_CH_OUT == $past(q.ptr);
   endproperty
   a_sample_ch: assert property (p_sample_ch)
      else $error("conversion did not sample the current channel");

   property p_single_hold;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_done && q.mode == MODE_SINGLE && !REG_WR_IN) |=> $stable(q.ptr);
   endproperty
   a_single_hold: assert property (p_single_hold)
      else $error("single-channel scheme moved the pointer after a conversion");

   property p_mux_hold;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && t_busy && q.cfg == CFG_SINGLE && !REG_WR_IN) |=> POS_SEL_OUT == CONV_CH_OUT;
   endproperty
   a_mux_hold: assert property (p_mux_hold)
      else $error("mux left the sampled channel during a conversion");

endmodule

// File: test/aics_host_model.sv
// Host side of the conversion start line: one falling edge per request.
// Assumes fire_in is a one-cycle pulse given only while the converter is idle.
`timescale 1ns/1ps
module aics_host_model
#(
   parameter int unsigned HOLD = 6
)(
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic fire_in,
   input  wire logic short_in,
   output logic      start_n_out
);
   logic [7:0] cnt_q;

   // Long hold releases only past the abort window; short one forces an abort
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         start_n_out <= 1'b1;
         cnt_q       <= 8'h00;
      end
      else if (fire_in && cnt_q == 8'h00)
      begin
         start_n_out <= 1'b0;
         cnt_q       <= short_in ? 8'h01 : 8'(HOLD);
      end
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01)
            start_n_out <= 1'b1;
      end
   end
endmodule

// File: test/tb_aics_sequencer.sv
// Testbench for the channel sequencer: register tasks and conversion requests.
// Assumes the short conversion parameters and the host model on the start line.
`timescale 1ns/1ps
module tb_aics_sequencer;
   import aics_pkg::*;
   localparam int unsigned CL = 4;
   localparam int unsigned AL = 2;

   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              ce = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              fire = 1'b0;
   logic              short_req = 1'b0;
   logic              start_n;
   logic [DATA_W-1:0] rdata;
   logic              busy, done, abort, neg_gnd, ref_int;
   logic [CH_W-1:0]   conv_ch, pos_sel, neg_sel;
   int                fail_count = 0;
   int                checks_done = 0;

   always #4 clk = ~clk;

   aics_host_model #(.HOLD(CL + 2)) u_aics_host_model (
      .clk_in(clk), .rst_in(rst), .fire_in(fire), .short_in(short_req),
      .start_n_out(start_n));

   aics_sequencer #(.CONV_LEN(CL), .ABORT_LEN(AL)) u_aics_sequencer (
      .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .CONV_START_N_IN(start_n), .REG_RDATA_OUT(rdata), .BUSY_OUT(busy),
      .CONV_DONE_OUT(done), .CONV_ABORT_OUT(abort), .CONV_CH_OUT(conv_ch),
      .POS_SEL_OUT(pos_sel), .NEG_SEL_OUT(neg_sel), .NEG_GND_OUT(neg_gnd),
      .REF_INTERNAL_OUT(ref_int));

   task automatic give_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask

   // One conversion request; checks busy, completion kind and channel
   task automatic conv(input logic [CH_W-1:0] exp_ch, input logic short_one);
      logic seen_busy;
      logic seen_end;
      seen_busy = 1'b0;
      seen_end  = 1'b0;
      @(posedge clk);
      fire      <= 1'b1;
      short_req <= short_one;
      @(posedge clk);
      fire      <= 1'b0;
      for (int i = 0; i < 40 && !seen_end; i++)
      begin
         @(posedge clk);
         #1;
         if (busy === 1'b1)
            seen_busy = 1'b1;
         if (done === 1'b1 || abort === 1'b1)
         begin
            seen_end = 1'b1;
            chk("done", {7'h0, ~short_one}, {7'h0, done});
            chk("abort", {7'h0, short_one}, {7'h0, abort});
            if (!short_one)
               chk("conv_ch", 8'(exp_ch), 8'(conv_ch));
         end
      end
      chk("busy_seen", 8'h01, {7'h0, seen_busy});
      chk("conv_end", 8'h01, {7'h0, seen_end});
      repeat (CL + 2) @(posedge clk);
   endtask

   task automatic chk_route(input logic [1:0] c, input logic [CH_W-1:0] ch, input logic r);
      logic [CH_W-1:0] ep;
      logic [CH_W-1:0] en;
      ep = (c == CFG_PSEUDO4) ? {ch[2:1], 1'b0} : ch;
      en = (c == CFG_PSEUDO4) ? {ch[2:1], 1'b1} : (c == CFG_DIFF4) ? (ch ^ 3'h1) : 3'h7;
      @(posedge clk);
      #1;
      chk("pos_sel", 8'(ep), 8'(pos_sel));
      chk("neg_gnd", {7'h0, c == CFG_SINGLE}, {7'h0, neg_gnd});
      if (c != CFG_SINGLE)
         chk("neg_sel", 8'(en), 8'(neg_sel));
      chk("ref_int", {7'h0, r}, {7'h0, ref_int});
   endtask

   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end

   initial
   begin
      logic [CH_W-1:0] ch;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("neg_gnd_rst", 8'h01, {7'h0, neg_gnd});
      chk("busy_rst", 8'h00, {7'h0, busy});
      rd_reg(REG_CTRL, 8'h00);
      rd_reg(REG_STATUS, 8'h00);
      rd_reg(2'h3, 8'h00);
      // Every configuration, two channels each, source bit toggled
      for (int c = 0; c < 4; c++)
         for (int k = 0; k < 2; k++)
         begin
            ch = (k == 0) ? 3'h5 : 3'h2;
            wr_reg(REG_CTRL, {c[0], ch, 2'b00, c[1:0]});
            chk_route(c[1:0], ch, c[0]);
         end
      conv(3'h2, 1'b0);
      conv(3'h2, 1'b0);
      rd_reg(REG_STATUS, 8'h04);
      wr_reg(REG_CTRL, 8'h60);
      conv(3'h6, 1'b0);
      // Mask scheme with wrap, continuation write and an abort
      wr_reg(REG_CTRL, 8'h08);
      wr_reg(REG_MASK, 8'h2c);
      rd_reg(REG_STATUS, 8'h14);
      conv(3'h2, 1'b0);
      conv(3'h3, 1'b0);
      conv(3'h5, 1'b0);
      conv(3'h2, 1'b0);
      wr_reg(REG_CTRL, 8'h75);
      conv(3'h3, 1'b0);
      conv(3'h5, 1'b1);
      rd_reg(REG_STATUS, 8'h5a);
      conv(3'h5, 1'b0);
      rd_reg(REG_STATUS, 8'h14);
      wr_reg(REG_CTRL, 8'h10);
      conv(3'h1, 1'b0);
      rd_reg(REG_STATUS, 8'h02);
      // Consecutive scheme up to channel 2
      wr_reg(REG_CTRL, 8'h2c);
      rd_reg(REG_CTRL, 8'h2c);
      conv(3'h0, 1'b0);
      conv(3'h1, 1'b0);
      conv(3'h2, 1'b0);
      conv(3'h0, 1'b0);
      // Refused writes: unmapped, status, clock enable low
      wr_reg(2'h3, 8'hff);
      wr_reg(REG_STATUS, 8'hff);
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(REG_CTRL, 8'h00);
      ce <= 1'b1;
      rd_reg(REG_CTRL, 8'h2c);
      rd_reg(REG_STATUS, 8'h22);
      give_verdict();
   end
endmodule
